//--- verilog/dtcpb_pkg.sv
package dtcpb_pkg;

	// ------------------------------------------------------------
	// Register offsets (word addresses)
	// ------------------------------------------------------------
	localparam logic [15:0] DTCPB_OFS_GEAR_NUM = 16'h161c;
	localparam logic [15:0] DTCPB_OFS_GEAR_DEN = 16'h161d;
	localparam logic [15:0] DTCPB_OFS_RSVD_A = 16'h161e;
	localparam logic [15:0] DTCPB_OFS_RAMP_SRC = 16'h161f;
	localparam logic [15:0] DTCPB_OFS_POS_SRC = 16'h1620;
	localparam logic [15:0] DTCPB_OFS_TRQ_SRC = 16'h1621;
	localparam logic [15:0] DTCPB_OFS_TRQ_VAL = 16'h1622;
	localparam logic [15:0] DTCPB_OFS_TRQ_SIGN = 16'h1623;
	localparam logic [15:0] DTCPB_OFS_OFF_MODE = 16'h1624;
	localparam logic [15:0] DTCPB_OFS_OFF_VAL = 16'h1625;
	localparam logic [15:0] DTCPB_OFS_OFF_SIGN = 16'h1626;
	localparam logic [15:0] DTCPB_OFS_FWD_HI = 16'h1627;
	localparam logic [15:0] DTCPB_OFS_FWD_LO = 16'h1628;
	localparam logic [15:0] DTCPB_OFS_REV_HI = 16'h1629;
	localparam logic [15:0] DTCPB_OFS_REV_LO = 16'h162a;
	localparam logic [15:0] DTCPB_OFS_RSVD_B = 16'h162b;
	localparam logic [15:0] DTCPB_OFS_RSVD_D = 16'h162d;
	localparam logic [15:0] DTCPB_OFS_WDOG = 16'h162e;
	localparam logic [15:0] DTCPB_OFS_ERR_ACT = 16'h162f;
	localparam logic [15:0] DTCPB_OFS_POLL_OUT = 16'h1630;
	localparam logic [15:0] DTCPB_OFS_IRQ_STAT = 16'h1680;
	localparam logic [15:0] DTCPB_OFS_IRQ_MASK = 16'h1681;

	// ------------------------------------------------------------
	// Value limits
	// ------------------------------------------------------------
	localparam logic [15:0] DTCPB_GEAR_MIN = 16'h0001;
	localparam logic [15:0] DTCPB_GEAR_MAX = 16'h270f;
	localparam logic [15:0] DTCPB_SRC3_MAX = 16'h0002;
	localparam logic [15:0] DTCPB_TRQ_SRC_MAX = 16'h0003;
	localparam logic [15:0] DTCPB_PCT_MAX = 16'h00b4;
	localparam logic [15:0] DTCPB_SIGN_MAX = 16'h0001;
	localparam logic [31:0] DTCPB_SPEED_MAX = 32'h0000_9c40;
	localparam logic [15:0] DTCPB_WDOG_MAX = 16'h270f;
	localparam logic [15:0] DTCPB_ERR_ACT_MAX = 16'h0004;
	localparam logic [15:0] DTCPB_INST_A = 16'h0014;
	localparam logic [15:0] DTCPB_INST_B = 16'h0015;
	localparam logic [15:0] DTCPB_INST_C = 16'h0064;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] DTCPB_RST_GEAR = 16'h0001;
	localparam logic [15:0] DTCPB_RST_ZERO = 16'h0000;
	localparam logic [15:0] DTCPB_RST_POLL_OUT = 16'h0014;

	// ------------------------------------------------------------
	// Interrupt status bit positions
	// ------------------------------------------------------------
	localparam int DTCPB_IRQ_WR_OK = 0;
	localparam int DTCPB_IRQ_WR_REJ = 1;
	localparam int DTCPB_IRQ_UNMAPPED = 2;
	localparam int DTCPB_IRQ_WIDTH = 3;

	// Communication error actions
	typedef enum logic [2:0] {
		DTCPB_ACT_TRIP,
		DTCPB_ACT_DECEL_TRIP,
		DTCPB_ACT_HOLD,
		DTCPB_ACT_COAST,
		DTCPB_ACT_DECEL_STOP
	} dtcpb_err_act_t;

endpackage

//--- verilog/dtcpb_range_check.sv
`timescale 1ns/1ns
// Decides whether a write value lies in the allowed set for an offset
module dtcpb_range_check import dtcpb_pkg::*; (
	// Candidate write
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	// Other half of a split speed limit
	input wire logic [15:0] partner_half,
	// Verdict
	output logic legal
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	wire logic [31:0] speed_as_hi = {wdata, partner_half};
	wire logic [31:0] speed_as_lo = {partner_half, wdata};
	wire logic is_hi = (addr == DTCPB_OFS_FWD_HI) || (addr == DTCPB_OFS_REV_HI);

	// Per-register value set
	always_comb begin
		unique case (addr)
			DTCPB_OFS_GEAR_NUM, DTCPB_OFS_GEAR_DEN:
				legal = in_range(wdata, DTCPB_GEAR_MIN, DTCPB_GEAR_MAX);
			DTCPB_OFS_RAMP_SRC, DTCPB_OFS_POS_SRC, DTCPB_OFS_OFF_MODE:
				legal = wdata <= DTCPB_SRC3_MAX;
			DTCPB_OFS_TRQ_SRC:
				legal = wdata <= DTCPB_TRQ_SRC_MAX;
			DTCPB_OFS_TRQ_VAL, DTCPB_OFS_OFF_VAL:
				legal = wdata <= DTCPB_PCT_MAX;
			DTCPB_OFS_TRQ_SIGN, DTCPB_OFS_OFF_SIGN:
				legal = wdata <= DTCPB_SIGN_MAX;
			DTCPB_OFS_FWD_HI, DTCPB_OFS_FWD_LO, DTCPB_OFS_REV_HI, DTCPB_OFS_REV_LO:
				legal = (is_hi ? speed_as_hi : speed_as_lo) <= DTCPB_SPEED_MAX;
			DTCPB_OFS_WDOG:
				legal = wdata <= DTCPB_WDOG_MAX;
			DTCPB_OFS_ERR_ACT:
				legal = wdata <= DTCPB_ERR_ACT_MAX;
			DTCPB_OFS_POLL_OUT:
				legal = (wdata == DTCPB_INST_A) || (wdata == DTCPB_INST_B) ||
					(wdata == DTCPB_INST_C);
			default:
				legal = 1'b0;
		endcase
	end

endmodule // dtcpb_range_check

//--- verilog/dtcpb_bank.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ns
// Summary of operation
// - Gear numerator register, 1 to 9999
// - Gear denominator register, 1 to 9999
// - Ramp time source: drive, card1, card2
// - Positioning source: drive, card1, card2
// - Torque source: voltage, current, voltage2, keypad
// - Keypad torque percentage, 0 to 180
// - Torque sign: signal or rotation direction
// - Bias mode 0-2, bias value 0-180
// - Bias sign: signal or rotation direction
// - Forward speed limit, two halves, max 40000
// - Reverse speed limit, same scaling
// - Watchdog timeout 0 to 9999 hundredths
// - Communication error action codes 0 to 4
// - Output instance only 20, 21, 100
module dtcpb_bank import dtcpb_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	// Settings toward motor control
	output logic [15:0] gear_num,
	output logic [15:0] gear_den,
	output logic [1:0] ramp_src,
	output logic [1:0] pos_src,
	output logic [1:0] trq_src,
	output logic [7:0] trq_cmd_pct,
	output logic trq_sign_follow_dir,
	output logic [1:0] trq_offset_mode,
	output logic [7:0] trq_offset_pct,
	output logic trq_offset_follow_dir,
	output logic [31:0] fwd_speed_limit,
	output logic [31:0] rev_speed_limit,
	output logic [15:0] wdog_timeout,
	output dtcpb_err_act_t err_action,
	output logic [15:0] poll_out_inst,
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [15:0] gear_num_r, gear_den_r, ramp_src_r, pos_src_r, trq_src_r;
	logic [15:0] trq_val_r, trq_sign_r, off_mode_r, off_val_r, off_sign_r;
	logic [15:0] fwd_hi_r, fwd_lo_r, rev_hi_r, rev_lo_r, wdog_r, err_act_r, poll_r;
	logic [15:0] rdata_r;
	logic [DTCPB_IRQ_WIDTH-1:0] irq_stat_r, irq_mask_r, irq_stat_nxt;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic is_rsvd(input logic [15:0] a);
		is_rsvd = (a == DTCPB_OFS_RSVD_A) || ((a >= DTCPB_OFS_RSVD_B) &&
			(a <= DTCPB_OFS_RSVD_D));
	endfunction

	function automatic logic is_param(input logic [15:0] a);
		is_param = (a >= DTCPB_OFS_GEAR_NUM) && (a <= DTCPB_OFS_POLL_OUT) && !is_rsvd(a);
	endfunction

	// Other half of the addressed speed limit
	logic [15:0] partner_half;
	always_comb begin
		unique case (addr)
			DTCPB_OFS_FWD_HI: partner_half = fwd_lo_r;
			DTCPB_OFS_FWD_LO: partner_half = fwd_hi_r;
			DTCPB_OFS_REV_HI: partner_half = rev_lo_r;
			DTCPB_OFS_REV_LO: partner_half = rev_hi_r;
			default: partner_half = DTCPB_RST_ZERO;
		endcase
	end

	wire logic legal;
	dtcpb_range_check u_check (
		.addr(addr),
		.wdata(wdata),
		.partner_half(partner_half),
		.legal(legal)
	);

	wire logic hit_param = is_param(addr);
	wire logic hit_rsvd = is_rsvd(addr);
	wire logic hit_stat = (addr == DTCPB_OFS_IRQ_STAT);
	wire logic hit_mask = (addr == DTCPB_OFS_IRQ_MASK);
	wire logic unmapped = !hit_param && !hit_rsvd && !hit_stat && !hit_mask;
	wire logic wr_ok = wr_en && hit_param && legal;
	wire logic wr_rej = wr_en && hit_param && !legal;

	// ------------------------------------------------------------
	// Parameter writes
	// ------------------------------------------------------------
	// Per-register strobes; accepted writes only, reserved never hit
	wire logic we_gear_num = wr_ok && (addr == DTCPB_OFS_GEAR_NUM);
	wire logic we_gear_den = wr_ok && (addr == DTCPB_OFS_GEAR_DEN);
	wire logic we_ramp_src = wr_ok && (addr == DTCPB_OFS_RAMP_SRC);
	wire logic we_pos_src = wr_ok && (addr == DTCPB_OFS_POS_SRC);
	wire logic we_trq_src = wr_ok && (addr == DTCPB_OFS_TRQ_SRC);
	wire logic we_trq_val = wr_ok && (addr == DTCPB_OFS_TRQ_VAL);
	wire logic we_trq_sign = wr_ok && (addr == DTCPB_OFS_TRQ_SIGN);
	wire logic we_off_mode = wr_ok && (addr == DTCPB_OFS_OFF_MODE);
	wire logic we_off_val = wr_ok && (addr == DTCPB_OFS_OFF_VAL);
	wire logic we_off_sign = wr_ok && (addr == DTCPB_OFS_OFF_SIGN);
	wire logic we_fwd_hi = wr_ok && (addr == DTCPB_OFS_FWD_HI);
	wire logic we_fwd_lo = wr_ok && (addr == DTCPB_OFS_FWD_LO);
	wire logic we_rev_hi = wr_ok && (addr == DTCPB_OFS_REV_HI);
	wire logic we_rev_lo = wr_ok && (addr == DTCPB_OFS_REV_LO);
	wire logic we_wdog = wr_ok && (addr == DTCPB_OFS_WDOG);
	wire logic we_err_act = wr_ok && (addr == DTCPB_OFS_ERR_ACT);
	wire logic we_poll = wr_ok && (addr == DTCPB_OFS_POLL_OUT);

	// ------------------------------------------------------------
	// Parameter registers
	// ------------------------------------------------------------
	// Gear ratio numerator
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			gear_num_r <= DTCPB_RST_GEAR;
		else if (we_gear_num)
			gear_num_r <= wdata;
	end

	// Gear ratio denominator
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			gear_den_r <= DTCPB_RST_GEAR;
		else if (we_gear_den)
			gear_den_r <= wdata;
	end

	// Ramp time source
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			ramp_src_r <= DTCPB_RST_ZERO;
		else if (we_ramp_src)
			ramp_src_r <= wdata;
	end

	// Positioning command source
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pos_src_r <= DTCPB_RST_ZERO;
		else if (we_pos_src)
			pos_src_r <= wdata;
	end

	// Torque command source
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			trq_src_r <= DTCPB_RST_ZERO;
		else if (we_trq_src)
			trq_src_r <= wdata;
	end

	// Keypad torque percentage
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			trq_val_r <= DTCPB_RST_ZERO;
		else if (we_trq_val)
			trq_val_r <= wdata;
	end

	// Torque sign source
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			trq_sign_r <= DTCPB_RST_ZERO;
		else if (we_trq_sign)
			trq_sign_r <= wdata;
	end

	// Bias mode
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			off_mode_r <= DTCPB_RST_ZERO;
		else if (we_off_mode)
			off_mode_r <= wdata;
	end

	// Bias percentage
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			off_val_r <= DTCPB_RST_ZERO;
		else if (we_off_val)
			off_val_r <= wdata;
	end

	// Bias sign source
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			off_sign_r <= DTCPB_RST_ZERO;
		else if (we_off_sign)
			off_sign_r <= wdata;
	end

	// Forward limit, upper half
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			fwd_hi_r <= DTCPB_RST_ZERO;
		else if (we_fwd_hi)
			fwd_hi_r <= wdata;
	end

	// Forward limit, lower half
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			fwd_lo_r <= DTCPB_RST_ZERO;
		else if (we_fwd_lo)
			fwd_lo_r <= wdata;
	end

	// Reverse limit, upper half
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rev_hi_r <= DTCPB_RST_ZERO;
		else if (we_rev_hi)
			rev_hi_r <= wdata;
	end

	// Reverse limit, lower half
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rev_lo_r <= DTCPB_RST_ZERO;
		else if (we_rev_lo)
			rev_lo_r <= wdata;
	end

	// Link watchdog timeout
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			wdog_r <= DTCPB_RST_ZERO;
		else if (we_wdog)
			wdog_r <= wdata;
	end

	// Action on link error
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			err_act_r <= DTCPB_RST_ZERO;
		else if (we_err_act)
			err_act_r <= wdata;
	end

	// Polled output instance
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			poll_r <= DTCPB_RST_POLL_OUT;
		else if (we_poll)
			poll_r <= wdata;
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Read mux; reserved and unmapped read zero
	logic [15:0] rd_mux;
	always_comb begin
		unique case (addr)
			DTCPB_OFS_GEAR_NUM: rd_mux = gear_num_r;
			DTCPB_OFS_GEAR_DEN: rd_mux = gear_den_r;
			DTCPB_OFS_RAMP_SRC: rd_mux = ramp_src_r;
			DTCPB_OFS_POS_SRC: rd_mux = pos_src_r;
			DTCPB_OFS_TRQ_SRC: rd_mux = trq_src_r;
			DTCPB_OFS_TRQ_VAL: rd_mux = trq_val_r;
			DTCPB_OFS_TRQ_SIGN: rd_mux = trq_sign_r;
			DTCPB_OFS_OFF_MODE: rd_mux = off_mode_r;
			DTCPB_OFS_OFF_VAL: rd_mux = off_val_r;
			DTCPB_OFS_OFF_SIGN: rd_mux = off_sign_r;
			DTCPB_OFS_FWD_HI: rd_mux = fwd_hi_r;
			DTCPB_OFS_FWD_LO: rd_mux = fwd_lo_r;
			DTCPB_OFS_REV_HI: rd_mux = rev_hi_r;
			DTCPB_OFS_REV_LO: rd_mux = rev_lo_r;
			DTCPB_OFS_WDOG: rd_mux = wdog_r;
			DTCPB_OFS_ERR_ACT: rd_mux = err_act_r;
			DTCPB_OFS_POLL_OUT: rd_mux = poll_r;
			DTCPB_OFS_IRQ_STAT: rd_mux = {13'h0000, irq_stat_r};
			DTCPB_OFS_IRQ_MASK: rd_mux = {13'h0000, irq_mask_r};
			default: rd_mux = DTCPB_RST_ZERO;
		endcase
	end

	// Read data valid the cycle after the strobe only
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rdata_r <= DTCPB_RST_ZERO;
		else
			rdata_r <= rd_en ? rd_mux : DTCPB_RST_ZERO;
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Sticky events; read of status clears, a new event wins
	wire logic [DTCPB_IRQ_WIDTH-1:0] irq_evt = {(wr_en || rd_en) && unmapped, wr_rej, wr_ok};
	assign irq_stat_nxt = ((rd_en && hit_stat) ? '0 : irq_stat_r) | irq_evt;

	// Status register
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			irq_stat_r <= '0;
		else
			irq_stat_r <= irq_stat_nxt;
	end

	// Mask register, written by software
	wire logic we_mask = wr_en && hit_mask;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			irq_mask_r <= '0;
		else if (we_mask)
			irq_mask_r <= wdata[DTCPB_IRQ_WIDTH-1:0];
	end

	// Level request while an unmasked bit is set
	assign irq = |(irq_stat_r & irq_mask_r);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata = rdata_r;
	assign gear_num = gear_num_r;
	assign gear_den = gear_den_r;
	assign ramp_src = ramp_src_r[1:0];
	assign pos_src = pos_src_r[1:0];
	assign trq_src = trq_src_r[1:0];
	assign trq_cmd_pct = trq_val_r[7:0];
	assign trq_sign_follow_dir = trq_sign_r[0];
	assign trq_offset_mode = off_mode_r[1:0];
	assign trq_offset_pct = off_val_r[7:0];
	assign trq_offset_follow_dir = off_sign_r[0];
	assign fwd_speed_limit = {fwd_hi_r, fwd_lo_r};
	assign rev_speed_limit = {rev_hi_r, rev_lo_r};
	assign wdog_timeout = wdog_r;
	assign err_action = dtcpb_err_act_t'(err_act_r[2:0]);
	assign poll_out_inst = poll_r;

endmodule // dtcpb_bank

//--- test/dtcpb_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// Register bank checker
// ----------------------------------------
module dtcpb_chk import dtcpb_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] rdata,
	// Settings
	input wire logic [15:0] gear_num,
	input wire logic [15:0] gear_den,
	input wire logic [7:0] trq_cmd_pct,
	input wire logic [31:0] fwd_speed_limit,
	input wire logic [31:0] rev_speed_limit,
	input wire logic [15:0] wdog_timeout,
	input wire dtcpb_err_act_t err_action,
	input wire logic [15:0] poll_out_inst
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Legal gear write, and read of a reserved word
	sequence s_gear_ok;
		wr_en && addr == 16'h161c && wdata != 16'h0000 && wdata <= 16'h270f;
	endsequence
	sequence s_rsvd_rd;
		rd_en && (addr == 16'h161e || (addr >= 16'h162b && addr <= 16'h162d));
	endsequence
	// Stored values stay inside their sets; legal writes stored, rejected kept, reserved reads zero
	a_gear_num_lim: assert property (gear_num != 16'h0000 && gear_num <= 16'h270f)
		else $error("gear numerator out of range");
	a_gear_den_lim: assert property (gear_den != 16'h0000 && gear_den <= 16'h270f)
		else $error("gear denominator out of range");
	a_gear_wr_take: assert property (s_gear_ok |=> gear_num == $past(wdata))
		else $error("legal gear write not stored");
	a_pct_lim: assert property (trq_cmd_pct <= 8'hb4)
		else $error("torque percent above bound");
	a_speed_lim: assert property (fwd_speed_limit <= 32'h0000_9c40 &&
		rev_speed_limit <= 32'h0000_9c40) else $error("speed limit above bound");
	a_wdog_lim: assert property (wdog_timeout <= 16'h270f)
		else $error("watchdog timeout out of range");
	a_err_act_lim: assert property (err_action <= DTCPB_ACT_DECEL_STOP)
		else $error("error action code out of range");
	a_poll_inst_set: assert property (poll_out_inst inside {16'h0014, 16'h0015, 16'h0064})
		else $error("output instance not allowed");
	a_rsvd_rd_zero: assert property (s_rsvd_rd |=> rdata == 16'h0000)
		else $error("reserved word read nonzero");
	a_reject_keep: assert property (wr_en && addr == 16'h1622 && wdata > 16'h00b4
		|=> $stable(trq_cmd_pct)) else $error("rejected write changed value");
endmodule // dtcpb_chk

bind dtcpb_bank dtcpb_chk i_chk (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .gear_num(gear_num), .gear_den(gear_den),
	.trq_cmd_pct(trq_cmd_pct), .fwd_speed_limit(fwd_speed_limit),
	.rev_speed_limit(rev_speed_limit), .wdog_timeout(wdog_timeout), .err_action(err_action),
	.poll_out_inst(poll_out_inst));

//--- test/dtcpb_master.sv
`timescale 1ns/1ns
// ----------------------------------------
// Network master model
// ----------------------------------------
module dtcpb_master (
	// Clock
	input wire logic clk,
	// Register port
	output logic [15:0] addr,
	output logic [15:0] wdata,
	output logic wr_en,
	output logic rd_en,
	input wire logic [15:0] rdata
);
	// Quiet bus at time zero
	initial begin
		addr = 16'h0000;
		wdata = 16'h0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	// One-cycle write; stale data inverted afterwards
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		wdata <= ~d;
		@(negedge clk);
	endtask
	// One-cycle read; data taken in the following cycle
	task rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
endmodule // dtcpb_master

//--- test/tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------
// Register bank testbench
// ----------------------------------------
module tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	wire logic [15:0] addr, wdata, rdata;
	wire logic wr_en, rd_en, irq;
	logic [15:0] gear_num, poll_out_inst, rd_v;
	logic [31:0] fwd_speed_limit, rev_speed_limit;
	logic [2:0] err_action;
	logic [15:0] gear_den, wdog_timeout;
	logic [7:0] trq_cmd_pct, trq_offset_pct;
	logic [1:0] ramp_src, pos_src, trq_src, trq_offset_mode;
	logic trq_sign_follow_dir, trq_offset_follow_dir;
	int failures = 0;
	int n_tests = 0;
	// Address, legal value, illegal value
	localparam logic [15:0] TAB [6][3] = '{'{16'h161c, 16'h270f, 16'h0000},
		'{16'h161d, 16'h270f, 16'h2710}, '{16'h1622, 16'h00b4, 16'h00b5},
		'{16'h1625, 16'h00b4, 16'h00b5}, '{16'h162e, 16'h270f, 16'h2710},
		'{16'h1630, 16'h0064, 16'h0016}};
	// Selector address and highest code
	localparam logic [15:0] SEL [7][2] = '{'{16'h161f, 16'h0002}, '{16'h1620, 16'h0002},
		'{16'h1621, 16'h0003}, '{16'h1623, 16'h0001}, '{16'h1624, 16'h0002},
		'{16'h1626, 16'h0001}, '{16'h162f, 16'h0004}};
	// Clock
	initial begin
		forever #20 clk = ~clk;
	end
	// Master and bank
	dtcpb_master i_mst (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata));
	dtcpb_bank i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .gear_num(gear_num), .gear_den(gear_den),
		.ramp_src(ramp_src), .pos_src(pos_src), .trq_src(trq_src), .trq_cmd_pct(trq_cmd_pct),
		.trq_sign_follow_dir(trq_sign_follow_dir), .trq_offset_mode(trq_offset_mode),
		.trq_offset_pct(trq_offset_pct), .trq_offset_follow_dir(trq_offset_follow_dir),
		.fwd_speed_limit(fwd_speed_limit), .rev_speed_limit(rev_speed_limit),
		.wdog_timeout(wdog_timeout), .err_action(err_action),
		.poll_out_inst(poll_out_inst), .irq(irq));
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task wr_rd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
		i_mst.wr(a, d);
		i_mst.rd(a, rd_v);
		chk("readback", rd_v, exp);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_values;
		chk("gear reset", gear_num, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			wr_rd(TAB[i][0], TAB[i][1], TAB[i][1]);
			wr_rd(TAB[i][0], TAB[i][2], TAB[i][1]);
		end
		chk("gear num", gear_num, 32'h0000_270f);
		chk("gear den", gear_den, 32'h0000_270f);
		chk("torque pct", trq_cmd_pct, 32'h0000_00b4);
		chk("bias pct", trq_offset_pct, 32'h0000_00b4);
		chk("watchdog", wdog_timeout, 32'h0000_270f);
		$display("test values done");
	endtask
	task t_codes;
		for (int i = 0; i < 7; i++) begin
			for (int k = 0; k <= SEL[i][1]; k++) begin
				wr_rd(SEL[i][0], k[15:0], k[15:0]);
			end
			wr_rd(SEL[i][0], SEL[i][1] + 16'h0001, SEL[i][1]);
		end
		chk("err action", 32'(err_action), 32'h0000_0004);
		chk("ramp src", ramp_src, 32'h0000_0002);
		chk("pos src", pos_src, 32'h0000_0002);
		chk("trq src", trq_src, 32'h0000_0003);
		chk("trq sign", trq_sign_follow_dir, 32'h0000_0001);
		chk("bias mode", trq_offset_mode, 32'h0000_0002);
		chk("bias sign", trq_offset_follow_dir, 32'h0000_0001);
		wr_rd(16'h1630, 16'h0014, 16'h0014);
		wr_rd(16'h1630, 16'h0015, 16'h0015);
		chk("poll port", poll_out_inst, 32'h0000_0015);
		$display("test codes done");
	endtask
	task t_speed;
		wr_rd(16'h1628, 16'h9c40, 16'h9c40);
		chk("fwd limit", fwd_speed_limit, 32'h0000_9c40);
		wr_rd(16'h1627, 16'h0001, 16'h0000);
		wr_rd(16'h162a, 16'h9c41, 16'h0000);
		wr_rd(16'h162a, 16'h9c40, 16'h9c40);
		chk("rev limit", rev_speed_limit, 32'h0000_9c40);
		$display("test speed done");
	endtask
	task t_rsvd;
		wr_rd(16'h161e, 16'hffff, 16'h0000);
		wr_rd(16'h162b, 16'hffff, 16'h0000);
		wr_rd(16'h162d, 16'h1234, 16'h0000);
		$display("test reserved done");
	endtask
	task t_irq;
		i_mst.wr(16'h1681, 16'h0000);
		i_mst.rd(16'h1680, rd_v);
		i_mst.wr(16'h161c, 16'h0000);
		chk("irq masked", irq, 32'h0000_0000);
		i_mst.wr(16'h1681, 16'h0002);
		chk("irq raised", irq, 32'h0000_0001);
		i_mst.rd(16'h1680, rd_v);
		chk("reject bit", rd_v & 16'h0002, 32'h0000_0002);
		chk("irq cleared", irq, 32'h0000_0000);
		i_mst.rd(16'h1700, rd_v);
		chk("unmapped read", rd_v, 32'h0000_0000);
		i_mst.wr(16'h1681, 16'h0004);
		chk("irq unmapped", irq, 32'h0000_0001);
		$display("test interrupt done");
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up;
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_values;
		t_codes;
		t_speed;
		t_rsvd;
		t_irq;
		wrap_up;
	end
endmodule // tb_top
